// ===== verilog/ulfc_cfg.svh
`ifndef ULFC_CFG_SVH
`define ULFC_CFG_SVH

// ==========================================================
// register byte offsets
`define ULFC_AW        4
`define ULFC_A_DATA    4'h0
`define ULFC_A_DIVH    4'h4
`define ULFC_A_STAT    4'h8
`define ULFC_A_LFC     4'hc

// ==========================================================
// line_format_control fields
`define ULFC_DIVISOR_ACCESS_BIT 7
`define ULFC_BREAK_BIT          6
`define ULFC_FORCED_PARITY_BIT  5
`define ULFC_PARITY_SENSE_BIT   4
`define ULFC_PARITY_ENABLE_BIT  3
`define ULFC_STOP_LENGTH_BIT    2
`define ULFC_WORD_LENGTH_HI     1
`define ULFC_WORD_LENGTH_LO     0

// ==========================================================
// reset values
`define ULFC_LFC_RST   8'h00
`define ULFC_DIV_RST   16'h000c
`define ULFC_EFR_RST   8'h00

// ==========================================================
// status register bits
`define ULFC_ST_RX_FULL  0
`define ULFC_ST_PAR_ERR  1
`define ULFC_ST_FRM_ERR  2
`define ULFC_ST_THR_EMPTY 3
`define ULFC_ST_TX_IDLE  4

// ==========================================================
// half-bit counts per line element
`define ULFC_HALF_START  3'h1
`define ULFC_HALF_BIT    3'h2
`define ULFC_HALF_STOP15 3'h3
`define ULFC_HALF_STOP2  3'h4

// ==========================================================
// bus responses
`define ULFC_OKAY      2'h0
`define ULFC_SLVERR    2'h2

`endif

// ===== verilog/ulfc_pkg.sv
`include "ulfc_cfg.svh"

package ulfc_pkg;

  // ==========================================================
  // types
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
    ulfc_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
    ulfc_rx_st_t;

  typedef struct packed {
    logic [1:0] wlen;
    logic       stop2;
    logic       par_en;
    logic       sense;
    logic       forced;
  } ulfc_fmt_t;

  typedef struct packed {
    ulfc_tx_st_t st;
    ulfc_fmt_t   f;
    logic [7:0]  sh;
    logic        par;
    logic [15:0] cnt;
    logic [2:0]  half;
    logic [2:0]  bitn;
    logic        txd;
    logic        busy;
  } ulfc_tx_s_t;

  typedef struct packed {
    logic [7:0]  lfc;
    logic [15:0] div;
    logic [7:0]  efr;
    logic [7:0]  thr;
    logic        thr_full;
    logic        tx_go;
    logic [7:0]  tx_byte;
    logic [7:0]  rbr;
    logic        rx_full;
    logic        perr;
    logic        ferr;
    logic        aw_ok;
    logic [3:0]  awaddr;
    logic        w_ok;
    logic [7:0]  wbyte;
    logic        wlane;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
    ulfc_rx_st_t rst;
    ulfc_fmt_t   rf;
    logic [15:0] rcnt;
    logic [2:0]  rhalf;
    logic [2:0]  rbitn;
    logic [7:0]  rsh;
    logic        rpar;
  } ulfc_s_t;

  // ==========================================================
  // format helpers
  function automatic ulfc_fmt_t ulfc_fmt_of(input logic [7:0] v);
    ulfc_fmt_t f;
    f.wlen   = v[`ULFC_WORD_LENGTH_HI:`ULFC_WORD_LENGTH_LO];
    f.stop2  = v[`ULFC_STOP_LENGTH_BIT];
    f.par_en = v[`ULFC_PARITY_ENABLE_BIT];
    f.sense  = v[`ULFC_PARITY_SENSE_BIT];
    f.forced = v[`ULFC_FORCED_PARITY_BIT];
    return f;
  endfunction : ulfc_fmt_of

  // data must already be masked to the word length
  function automatic logic ulfc_par(input logic [7:0] d,
                                    input ulfc_fmt_t f);
    return f.forced ? ~f.sense : (f.sense ? ^d : ~(^d));
  endfunction : ulfc_par

  // index of the last data bit, 4..7
  function automatic logic [2:0] ulfc_last(input ulfc_fmt_t f);
    return {1'b0, f.wlen} + 3'h4;
  endfunction : ulfc_last

  function automatic logic [2:0] ulfc_stop_halves(input ulfc_fmt_t f);
    if (!f.stop2)
      return `ULFC_HALF_BIT;
    return (f.wlen == 2'h0) ? `ULFC_HALF_STOP15 : `ULFC_HALF_STOP2;
  endfunction : ulfc_stop_halves

endpackage : ulfc_pkg

// ===== verilog/ulfc_tx.sv
`timescale 1ns/1ps
`include "ulfc_cfg.svh"

module ulfc_tx (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [15:0]       div,
  input  wire logic [7:0]        lfc,
  input  wire logic              start,
  input  wire logic [7:0]        data,
  output logic                   busy,
  output logic                   txd
);

  ulfc_pkg::ulfc_tx_s_t s_r;
  ulfc_pkg::ulfc_tx_s_t s_nxt;
  logic [15:0]          lim;
  logic                 tick;
  logic [2:0]           need;
  logic                 done;
  logic [7:0]           md;
  ulfc_pkg::ulfc_fmt_t  f0;

  // ==========================================================
  // serializer, half-bit time base
  always_comb
  begin
    s_nxt = s_r;
    f0    = ulfc_pkg::ulfc_fmt_of(lfc);
    md    = data >> (3'h7 - ulfc_pkg::ulfc_last(f0));
    lim   = (div == 16'h0000) ? 16'h0000 : div - 16'h0001;
    tick  = (s_r.cnt >= lim);
    need  = (s_r.st == ulfc_pkg::TX_STOP) ?
            ulfc_pkg::ulfc_stop_halves(s_r.f) : `ULFC_HALF_BIT;
    done  = tick && (s_r.half == need - 3'h1);
    if (s_r.st != ulfc_pkg::TX_IDLE)
    begin
      s_nxt.cnt  = tick ? 16'h0000 : s_r.cnt + 16'h0001;
      s_nxt.half = !tick ? s_r.half : (done ? 3'h0 : s_r.half + 3'h1);
    end
    unique case (s_r.st)
      ulfc_pkg::TX_IDLE:
        if (start)
        begin
          // format frozen here so a mid-character write cannot hurt
          s_nxt.f    = f0;
          s_nxt.sh   = data;
          s_nxt.par  = ulfc_pkg::ulfc_par(md, f0);
          s_nxt.cnt  = 16'h0000;
          s_nxt.half = 3'h0;
          s_nxt.bitn = 3'h0;
          s_nxt.st   = ulfc_pkg::TX_START;
        end
      ulfc_pkg::TX_START:
        if (done)
          s_nxt.st = ulfc_pkg::TX_DATA;
      ulfc_pkg::TX_DATA:
        if (done)
        begin
          s_nxt.sh   = s_r.sh >> 1;
          s_nxt.bitn = s_r.bitn + 3'h1;
          if (s_r.bitn == ulfc_pkg::ulfc_last(s_r.f))
            s_nxt.st = s_r.f.par_en ? ulfc_pkg::TX_PAR
                                    : ulfc_pkg::TX_STOP;
        end
      ulfc_pkg::TX_PAR:
        if (done)
          s_nxt.st = ulfc_pkg::TX_STOP;
      ulfc_pkg::TX_STOP:
        if (done)
          s_nxt.st = ulfc_pkg::TX_IDLE;
    endcase
    s_nxt.busy = (s_nxt.st != ulfc_pkg::TX_IDLE);
    // line level of the next state; break overrides everything
    unique case (s_nxt.st)
      ulfc_pkg::TX_START: s_nxt.txd = 1'b0;
      ulfc_pkg::TX_DATA:  s_nxt.txd = s_nxt.sh[0];
      ulfc_pkg::TX_PAR:   s_nxt.txd = s_nxt.par;
      default:            s_nxt.txd = 1'b1;
    endcase
    if (lfc[`ULFC_BREAK_BIT])
      s_nxt.txd = 1'b0;
  end

  // ==========================================================
  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r     <= '0;
      s_r.txd <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign busy = s_r.busy;
  assign txd  = s_r.txd;

endmodule : ulfc_tx

// ===== verilog/ulfc_top.sv
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ulfc_cfg.svh"

module ulfc_top (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [3:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [3:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   txd,
  input  wire logic              rxd
);

  ulfc_pkg::ulfc_s_t    s_r;
  ulfc_pkg::ulfc_s_t    s_nxt;
  logic                 tx_busy;
  logic                 dlab;
  logic [15:0]          rlim;
  logic                 rtick;
  logic [2:0]           rneed;
  logic                 rdone;
  logic [7:0]           rword;

  // ==========================================================
  // transmitter
  // the serializer reads the live format register but freezes its own
  // copy at launch, so only the break bit acts in mid-character; the
  // divisor is also live, so software should change it only while the
  // line is idle, or the character in flight is stretched or squeezed
  ulfc_tx u_tx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .div     (s_r.div),
    .lfc     (s_r.lfc),
    .start   (s_r.tx_go),
    .data    (s_r.tx_byte),
    .busy    (tx_busy),
    .txd     (txd)
  );

  // ==========================================================
  // next-state logic
  always_comb
  begin
    s_nxt = s_r;
    dlab  = s_r.lfc[`ULFC_DIVISOR_ACCESS_BIT];

    // write address and data are taken independently
    // each half is parked in its own holding flop, so a master that
    // offers data before the address (or the other way round) is served
    // without a combinational path from valid to ready
    if (s_r.bvalid && s_axi_bready)
      s_nxt.bvalid = 1'b0;
    if (s_axi_awvalid && s_r.awready)
    begin
      s_nxt.aw_ok  = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready)
    begin
      s_nxt.w_ok  = 1'b1;
      s_nxt.wbyte = s_axi_wdata[7:0];
      s_nxt.wlane = s_axi_wstrb[0];
    end

    // hand the holding byte to the serializer when it is free;
    // tx_go guards against a second launch before busy rises
    s_nxt.tx_go = 1'b0;
    if (s_r.thr_full && !tx_busy && !s_r.tx_go)
    begin
      s_nxt.tx_go    = 1'b1;
      s_nxt.tx_byte  = s_r.thr;
      s_nxt.thr_full = 1'b0;
    end

    // register write once both halves are held
    // the answer waits until the old response has been taken, so one
    // write at most is in flight; the decode uses the access bit as it
    // stood before this write, so a write that flips the access bit
    // only changes the map for the next transfer
    // a lane 0 strobe of zero stores nothing but still answers okay where the register is writable
    if (s_r.aw_ok && s_r.w_ok && !s_r.bvalid)
    begin
      s_nxt.aw_ok  = 1'b0;
      s_nxt.w_ok   = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = `ULFC_OKAY;
      case (s_r.awaddr)
        `ULFC_A_LFC:
          if (s_r.wlane)
            s_nxt.lfc = s_r.wbyte;
        `ULFC_A_DATA:
          if (dlab)
          begin
            if (s_r.wlane)
              s_nxt.div[7:0] = s_r.wbyte;
          end
          else if (s_r.wlane)
          begin
            s_nxt.thr      = s_r.wbyte;
            s_nxt.thr_full = 1'b1;
          end
        `ULFC_A_DIVH:
          if (!dlab)
            s_nxt.bresp = `ULFC_SLVERR;
          else if (s_r.wlane)
            s_nxt.div[15:8] = s_r.wbyte;
        `ULFC_A_STAT:
          if (!dlab)
            s_nxt.bresp = `ULFC_SLVERR;
          else if (s_r.wlane)
            s_nxt.efr = s_r.wbyte;
        default:
          s_nxt.bresp = `ULFC_SLVERR;
      endcase
    end

    // register read; answer one cycle after the address is taken
    // the read data is captured in the accepting cycle, so a status bit
    // that changes while the answer waits for rready is not seen until
    // the next read; side effects (flag clears) happen once, at accept
    // hidden registers answer with an error and zero data rather than
    // silently aliasing, so software notices a wrong access bit
    if (s_r.rvalid && s_axi_rready)
      s_nxt.rvalid = 1'b0;
    if (s_axi_arvalid && s_r.arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = `ULFC_OKAY;
      s_nxt.rdata  = 8'h00;
      case (s_axi_araddr)
        `ULFC_A_LFC:
          s_nxt.rdata = s_r.lfc;
        `ULFC_A_DATA:
          if (dlab)
            s_nxt.rdata = s_r.div[7:0];
          else
          begin
            s_nxt.rdata   = s_r.rbr;
            s_nxt.rx_full = 1'b0;
          end
        `ULFC_A_DIVH:
          if (dlab)
            s_nxt.rdata = s_r.div[15:8];
          else
            s_nxt.rresp = `ULFC_SLVERR;
        `ULFC_A_STAT:
          if (dlab)
            s_nxt.rdata = s_r.efr;
          else
          begin
            s_nxt.rdata[`ULFC_ST_RX_FULL]   = s_r.rx_full;
            s_nxt.rdata[`ULFC_ST_PAR_ERR]   = s_r.perr;
            s_nxt.rdata[`ULFC_ST_FRM_ERR]   = s_r.ferr;
            s_nxt.rdata[`ULFC_ST_THR_EMPTY] = ~s_r.thr_full;
            s_nxt.rdata[`ULFC_ST_TX_IDLE]   =
              ~(tx_busy | s_r.thr_full | s_r.tx_go);
            // error flags clear on read; a new error below still wins
            s_nxt.perr = 1'b0;
            s_nxt.ferr = 1'b0;
          end
        default:
          s_nxt.rresp = `ULFC_SLVERR;
      endcase
    end

    // receiver time base: one tick per half bit
    // the half-bit grain lets the start bit be checked at its middle
    // and every later bit be sampled a full bit time apart; a divisor
    // of zero is treated as one so the counter never stalls
    rlim  = (s_r.div == 16'h0000) ? 16'h0000 : s_r.div - 16'h0001;
    rtick = (s_r.rcnt >= rlim);
    rneed = (s_r.rst == ulfc_pkg::RX_START) ? `ULFC_HALF_START
                                             : `ULFC_HALF_BIT;
    rdone = rtick && (s_r.rhalf == rneed - 3'h1);
    rword = s_r.rsh >> (3'h7 - ulfc_pkg::ulfc_last(s_r.rf));
    if (s_r.rst != ulfc_pkg::RX_IDLE)
    begin
      s_nxt.rcnt  = rtick ? 16'h0000 : s_r.rcnt + 16'h0001;
      s_nxt.rhalf = !rtick ? s_r.rhalf
                           : (rdone ? 3'h0 : s_r.rhalf + 3'h1);
    end

    // receiver: samples at mid bit, only the first stop bit is checked
    // limitation: a second stop bit or the half stop is not sampled, and
    // the receiver rearms at mid stop, so it tolerates a peer whose
    // clock runs slightly fast; a glitch that is high again at the
    // middle of the start bit is dropped as a false start
    // the format is frozen at the start edge for the same reason as on
    // the transmit side
    unique case (s_r.rst)
      ulfc_pkg::RX_IDLE:
        if (!rxd)
        begin
          s_nxt.rf    = ulfc_pkg::ulfc_fmt_of(s_r.lfc);
          s_nxt.rcnt  = 16'h0000;
          s_nxt.rhalf = 3'h0;
          s_nxt.rbitn = 3'h0;
          s_nxt.rst   = ulfc_pkg::RX_START;
        end
      ulfc_pkg::RX_START:
        if (rdone)
          s_nxt.rst = rxd ? ulfc_pkg::RX_IDLE : ulfc_pkg::RX_DATA;
      ulfc_pkg::RX_DATA:
        if (rdone)
        begin
          s_nxt.rsh   = {rxd, s_r.rsh[7:1]};
          s_nxt.rbitn = s_r.rbitn + 3'h1;
          if (s_r.rbitn == ulfc_pkg::ulfc_last(s_r.rf))
            s_nxt.rst = s_r.rf.par_en ? ulfc_pkg::RX_PAR
                                      : ulfc_pkg::RX_STOP;
        end
      ulfc_pkg::RX_PAR:
        if (rdone)
        begin
          s_nxt.rpar = rxd;
          s_nxt.rst  = ulfc_pkg::RX_STOP;
        end
      ulfc_pkg::RX_STOP:
        if (rdone)
        begin
          s_nxt.rst     = ulfc_pkg::RX_IDLE;
          s_nxt.rbr     = rword;
          s_nxt.rx_full = 1'b1;
          if (!rxd)
            s_nxt.ferr = 1'b1;
          if (s_r.rf.par_en &&
              s_r.rpar != ulfc_pkg::ulfc_par(rword, s_r.rf))
            s_nxt.perr = 1'b1;
        end
    endcase

    // ready flags registered so every bus output leaves a flop
    // they are derived from the next state, so ready drops in the same
    // edge that takes a transfer and a second one cannot slip in
    s_nxt.awready = ~s_nxt.aw_ok & ~s_nxt.bvalid;
    s_nxt.wready  = ~s_nxt.w_ok & ~s_nxt.bvalid;
    s_nxt.arready = ~s_nxt.rvalid;
  end

  // ==========================================================
  // state register
  // reset clears the whole struct, then sets the few fields whose idle
  // value is not zero; the bus is ready to take a request in the first
  // cycle after reset is released
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r         <= '0;
      s_r.lfc     <= `ULFC_LFC_RST;
      s_r.div     <= `ULFC_DIV_RST;
      s_r.efr     <= `ULFC_EFR_RST;
      s_r.awready <= 1'b1;
      s_r.wready  <= 1'b1;
      s_r.arready <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // ==========================================================
  // bus outputs
  // only one byte lane carries data; the upper lanes read as zero
  assign s_axi_awready = s_r.awready;
  assign s_axi_wready  = s_r.wready;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rresp   = s_r.rresp;
  assign s_axi_rdata   = {24'h000000, s_r.rdata};

endmodule : ulfc_top

// ===== dv/ulfc_checker.sv
`timescale 1ns/1ps
// ==========================================
// bus and line checks on the top ports
module ulfc_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        txd
);
  logic brk_r;
  // shadow of the break bit; assumes address and data are taken together
  always_ff @(posedge aclk)
    if (!aresetn)
      brk_r <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
             && s_axi_awaddr == 4'hc && s_axi_wstrb[0])
      brk_r <= s_axi_wdata[6];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_rst_idle;
    $rose(aresetn) |-> txd && s_axi_awready && s_axi_arready
      && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("bad reset state");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_r_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  property p_w_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_w_ans: assert property (p_w_ans) else $error("write answer timing");
  property p_aw_drop;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2];
  endproperty
  a_aw_drop: assert property (p_aw_drop) else $error("second write taken");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_ready_back;
    s_axi_bvalid && s_axi_bready |=> ##1 s_axi_awready && s_axi_wready;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("ready not back");
  property p_break;
    brk_r && $past(brk_r, 3) |-> !txd;
  endproperty
  a_break: assert property (p_break) else $error("break not on line");
endmodule : ulfc_checker

bind ulfc_top ulfc_checker u_chk (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .txd);

// ===== dv/ulfc_peer.sv
`timescale 1ns/1ps
// ==========================================
// remote serial peer, one bit is BITC clocks
module ulfc_peer #(
  parameter int BITC = 4
) (
  input wire logic aclk,
  input wire logic txd,
  output logic     rxd
);
  int cyc = 0;
  initial rxd = 1'b1;
  // free count to time start edges
  always @(posedge aclk)
    cyc <= cyc + 1;

  task automatic put(input logic v, input int c);
    rxd <= v;
    repeat (c) @(posedge aclk);
  endtask : put

  // frame onto rxd; line rests high after the stop
  task automatic send(input logic [7:0] d, input int n, input logic pen,
                      input logic pb, input int halves);
    @(posedge aclk);
    put(1'b0, BITC);
    for (int i = 0; i < n; i++)
      put(d[i], BITC);
    if (pen)
      put(pb, BITC);
    put(1'b1, halves * BITC / 2);
  endtask : send

  // waits for stop level first so a low last bit is not a start
  task automatic recv(input int n, input logic pen, output logic [7:0] d,
                      output logic p, output int t0);
    d = 8'h00;
    p = 1'b0;
    @(negedge aclk);
    while (txd !== 1'b1)
      @(negedge aclk);
    while (txd !== 1'b0)
      @(negedge aclk);
    t0 = cyc;
    repeat (BITC / 2) @(negedge aclk);
    for (int i = 0; i < n; i++)
    begin
      repeat (BITC) @(negedge aclk);
      d[i] = txd;
    end
    if (pen)
    begin
      repeat (BITC) @(negedge aclk);
      p = txd;
    end
  endtask : recv
endmodule : ulfc_peer

// ===== dv/tb_uart_line_format_control.sv
`timescale 1ns/1ps
module tb_uart_line_format_control;
  localparam int BITC = 4;  // divisor 2 half-bit clocks
  localparam int LIMIT = 20000;
  logic aclk, aresetn, txd, rxd;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int num_errors = 0, n_compared = 0, cyc = 0;
  logic [7:0] fmts [7] = '{8'h00, 8'h05, 8'h0a, 8'h1b, 8'h2c, 8'h3f, 8'h34};

  ulfc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .txd, .rxd);
  ulfc_peer #(.BITC(BITC)) peer (.aclk, .txd, .rxd);

  // ==========================================
  // clock and hang guard
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      num_errors++;
      test_done();
    end
  end

  task test_done();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic epar(input logic [7:0] d, input logic [7:0] f);
    return f[5] ? ~f[4] : (f[4] ? ^d : ~^d);
  endfunction : epar

  // ==========================================
  // bus master: offers address and data together
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !wd;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({6'h0, s_axi_bresp}, {6'h0, er});
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] ed,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata[7:0], ed);
    chk({6'h0, s_axi_rresp}, {6'h0, er});
  endtask : rd

  // ==========================================
  // scenarios
  task automatic t_regs();
    rd(4'hc, 8'h00, 2'h0);
    wr(4'hc, 8'h80, 2'h0);
    rd(4'h0, 8'h0c, 2'h0);
    rd(4'h4, 8'h00, 2'h0);
    rd(4'h8, 8'h00, 2'h0);
    wr(4'h0, 8'h02, 2'h0);
    wr(4'h8, 8'ha5, 2'h0);
    rd(4'h8, 8'ha5, 2'h0);
    rd(4'h0, 8'h02, 2'h0);
    rd(4'h2, 8'h00, 2'h2);
    wr(4'hc, 8'h03, 2'h0);
    rd(4'h4, 8'h00, 2'h2);
    wr(4'h4, 8'h01, 2'h2);
    rd(4'h8, 8'h18, 2'h0);
  endtask : t_regs

  // two bytes back to back: the start gap shows parity and stop length
  task automatic t_tx();
    logic [7:0] a, b, m;
    logic pa, pb;
    int n, h, t1, t2, per;
    foreach (fmts[k])
    begin
      n = 5 + fmts[k][1:0];
      h = !fmts[k][2] ? 2 : (n == 5 ? 3 : 4);
      per = (1 + n + fmts[k][3]) * BITC + h * BITC / 2;
      m = 8'hff >> (8 - n);
      wr(4'hc, fmts[k], 2'h0);
      fork
        begin
          peer.recv(n, fmts[k][3], a, pa, t1);
          peer.recv(n, fmts[k][3], b, pb, t2);
        end
        begin
          wr(4'h0, 8'hb5, 2'h0);
          wr(4'h0, 8'h4c, 2'h0);
        end
      join
      chk(a, 8'hb5 & m);
      chk(b, 8'h4c & m);
      if (fmts[k][3])
        chk({7'h0, pa}, {7'h0, epar(8'hb5 & m, fmts[k])});
      chk({7'h0, t2 - t1 >= per && t2 - t1 <= per + 2}, 8'h01);
    end
  endtask : t_tx

  // format rewritten mid character; the character keeps the old one
  task automatic t_late();
    logic [7:0] a;
    logic pa;
    int t1;
    wr(4'hc, 8'h03, 2'h0);
    fork
      peer.recv(8, 1'b0, a, pa, t1);
      begin
        wr(4'h0, 8'h96, 2'h0);
        repeat (8) @(posedge aclk);
        wr(4'hc, 8'h00, 2'h0);
      end
    join
    chk(a, 8'h96);
  endtask : t_late

  task automatic t_break();
    wr(4'hc, 8'h43, 2'h0);
    repeat (6) @(posedge aclk);
    chk({7'h0, txd}, 8'h00);
    repeat (40) @(posedge aclk);
    chk({7'h0, txd}, 8'h00);
    wr(4'hc, 8'h03, 2'h0);
    repeat (4) @(posedge aclk);
    chk({7'h0, txd}, 8'h01);
  endtask : t_break

  task automatic rx1(input logic [7:0] f, input logic [7:0] d,
                     input logic pb, input logic [7:0] st);
    wr(4'hc, f, 2'h0);
    peer.send(d, 5 + f[1:0], f[3], pb, 2);
    repeat (2) @(posedge aclk);
    rd(4'h8, st, 2'h0);
    rd(4'h0, d & (8'hff >> (3 - f[1:0])), 2'h0);
  endtask : rx1

  task automatic t_rx();
    rx1(8'h1b, 8'h5a, epar(8'h5a, 8'h1b), 8'h19);
    rx1(8'h1b, 8'h5a, ~epar(8'h5a, 8'h1b), 8'h1b);
    rx1(8'h38, 8'h15, 1'b0, 8'h19);
    rx1(8'h2a, 8'h33, 1'b0, 8'h1b);
    rx1(8'h3a, 8'h33, 1'b0, 8'h19);
  endtask : t_rx

  // main sequence, reset held four clocks
  initial
  begin
    aresetn = 1'b0;
    s_axi_wstrb = 4'h1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_tx();
    t_late();
    t_break();
    t_rx();
    test_done();
  end
endmodule : tb_uart_line_format_control
